// ---- core/rdq_consts.vh ----
// constants for the receive done-queue writer
`ifndef RDQ_CONSTS_VH
`define RDQ_CONSTS_VH
`define RDQ_AW            12
`define RDQ_DW            16
`define RDQ_OFF_BASE_LO   12'h730
`define RDQ_OFF_BASE_HI   12'h734
`define RDQ_OFF_END       12'h738
`define RDQ_OFF_RD_PTR    12'h73C
`define RDQ_OFF_WR_PTR    12'h740
`define RDQ_OFF_TIMER     12'h744
`define RDQ_OFF_STATUS    12'h750
`define RDQ_OFF_IRQ_EN    12'h754
`define RDQ_OFF_CTRL      12'h780
`define RDQ_RST_REG       16'h0000
`define RDQ_CTRL_MASK     16'h0730
`define RDQ_CTRL_BURST_EN 4
`define RDQ_CTRL_FLUSH    5
`define RDQ_CTRL_THR_LSB  8
`define RDQ_STAT_DONE     0
`define RDQ_STAT_ERR      1
`define RDQ_FIFO_DEPTH    8
`define RDQ_HIGH_WMARK    6
`define RDQ_PRESCALE      256
`define RDQ_TIMER_MAX     17'h10000
`endif

// ---- core/rdq_fifo.v ----
// descriptor burst fifo with head peek and occupancy count
`timescale 1ns/100ps
module rdq_fifo #(
  parameter W     = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire          i_mclk,
  input  wire          i_rst_n,
  input  wire          i_push,
  input  wire [W-1:0]  i_data,
  input  wire          i_pop,
  output wire [W-1:0]  o_head,
  output wire [AW:0]   o_count
);
  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         do_push;
  wire         do_pop;

  // pushes into a full fifo and pops from an empty one are dropped
  assign do_push = i_push && (cnt_q != DEPTH[AW:0]);
  assign do_pop  = i_pop && (cnt_q != {(AW+1){1'b0}});
  assign o_head  = mem[rd_q];
  assign o_count = cnt_q;

  always @(posedge i_mclk)
  begin
    if (do_push)
    begin
      mem[wr_q] <= i_data;
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // rdq_fifo

// ---- core/rdq_writer.v ----
// receive done-queue writer: descriptor posting, burst fifo, pointers, flush timer
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`include "rdq_consts.vh"
module rdq_writer #(
  parameter DEPTH = `RDQ_FIFO_DEPTH,
  parameter HWM   = `RDQ_HIGH_WMARK
) (
  input  wire                i_mclk,
  input  wire                i_rst_n,
  input  wire [`RDQ_AW-1:0]  i_addr,
  input  wire [`RDQ_DW-1:0]  i_wdata,
  input  wire                i_wr,
  input  wire                i_rd,
  output reg  [`RDQ_DW-1:0]  o_rdata,
  input  wire                i_rx_dma_enable,
  input  wire                i_buf_valid,
  input  wire                i_buf_eof,
  input  wire [2:0]          i_buf_status,
  input  wire [2:0]          i_buf_count,
  input  wire [2:0]          i_buf_post_threshold,
  input  wire [7:0]          i_buf_channel,
  input  wire [15:0]         i_buf_desc_ptr,
  output reg                 o_buf_ready,
  output reg                 o_mem_req,
  output reg  [31:0]         o_mem_addr,
  output reg  [31:0]         o_mem_data,
  output reg                 o_mem_last,
  input  wire                i_mem_ack,
  output reg                 o_irq
);
  localparam S_IDLE = 2'b00;
  localparam S_XFER = 2'b01;
  localparam S_NEXT = 2'b10;

  reg  [15:0] base_lo_q;
  reg  [15:0] base_hi_q;
  reg  [15:0] end_q;
  reg  [15:0] rp_q;
  reg  [15:0] wp_q;
  reg  [15:0] reload_q;
  reg  [15:0] ctrl_q;
  reg  [1:0]  stat_q;
  reg  [1:0]  ien_q;
  reg  [1:0]  state_q;
  reg  [3:0]  left_q;
  reg  [7:0]  wcnt_q;
  reg  [7:0]  pre_q;
  reg  [16:0] tmr_q;
  reg         blocked_q;

  wire [31:0] head;
  wire [3:0]  fcnt;
  wire        burst_en;
  wire        flush;
  wire [2:0]  thr_code;
  wire [31:0] base;
  wire [15:0] wp_inc;
  wire [15:0] wp_adv;
  wire        q_full;
  wire [16:0] room;
  wire [16:0] to_end;
  wire        post;
  wire [31:0] desc;
  wire        push;
  wire        pop;
  wire        ack;
  wire        host_wr;
  wire [8:0]  wcnt_inc;
  wire [8:0]  stat_lim;
  wire        done_set;
  reg         err_set;
  reg         start;
  reg         drop;
  reg  [3:0]  want;
  reg  [3:0]  burst_n;
  reg  [3:0]  cnt_nx;

  assign burst_en = ctrl_q[`RDQ_CTRL_BURST_EN];
  assign flush    = ctrl_q[`RDQ_CTRL_FLUSH];
  assign thr_code = ctrl_q[`RDQ_CTRL_THR_LSB+2:`RDQ_CTRL_THR_LSB];
  assign base     = {base_hi_q, base_lo_q};
  assign host_wr  = i_wr && (i_addr == `RDQ_OFF_WR_PTR);

  // pointer is a dword index; past the end index it returns to the base
  assign wp_inc = wp_q + 16'h0001;
  assign wp_adv = (wp_inc > end_q) ? 16'h0000 : wp_inc;
  assign q_full = (wp_adv == rp_q);
  // free slots keep one entry unused; equal pointers mean an empty queue
  assign room = (rp_q > wp_q) ? ({1'b0, rp_q} - {1'b0, wp_q} - 17'h00001)
                              : ({1'b0, end_q} - {1'b0, wp_q} + {1'b0, rp_q});
  // bursts stop at the wrap so the address stays linear inside a burst
  assign to_end = {1'b0, end_q} - {1'b0, wp_q} + 17'h00001;

  assign post = i_buf_eof || ((i_buf_post_threshold != 3'b000) &&
                (i_buf_count >= i_buf_post_threshold));
  assign desc = {1'b0, i_buf_eof, i_buf_status,
                 (i_buf_post_threshold == 3'b000) ? 3'b000 : i_buf_count,
                 i_buf_channel, i_buf_desc_ptr};
  assign push = i_buf_valid && o_buf_ready && post;
  assign ack  = (state_q == S_XFER) && i_mem_ack;
  assign pop  = ack || drop;

  assign wcnt_inc = {1'b0, wcnt_q} + 9'h001;
  assign stat_lim = 9'h001 << thr_code;
  assign done_set = ack && (wcnt_inc >= stat_lim);

  rdq_fifo #(
    .W     (32),
    .DEPTH (DEPTH),
    .AW    (3)
  ) i_rdq_fifo (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_push  (push),
    .i_data  (desc),
    .i_pop   (pop),
    .o_head  (head),
    .o_count (fcnt)
  );

  always @*
  begin
    cnt_nx = fcnt;
    if (push && !pop)
    begin
      cnt_nx = fcnt + 4'h1;
    end
    else if (pop && !push)
    begin
      cnt_nx = fcnt - 4'h1;
    end
  end

  always @*
  begin
    want    = 4'h0;
    burst_n = 4'h0;
    start   = 1'b0;
    drop    = 1'b0;
    err_set = 1'b0;
    if ((state_q == S_IDLE) && i_rx_dma_enable && !host_wr && (fcnt != 4'h0))
    begin
      if (!burst_en)
      begin
        want = 4'h1;
      end
      else if ((fcnt >= HWM[3:0]) || flush || (tmr_q == 17'h00000))
      begin
        want = fcnt;
      end
      else
      begin
        want = 4'h0;
      end
      if (flush && !burst_en)
      begin
        want = 4'h1;
      end
      burst_n = want;
      if ({13'h0000, burst_n} > room)
      begin
        burst_n = room[3:0];
      end
      if ({13'h0000, burst_n} > to_end)
      begin
        burst_n = to_end[3:0];
      end
      if ((want != 4'h0) && (room == 17'h00000 || q_full))
      begin
        if (!burst_en)
        begin
          err_set = 1'b1;
          drop    = 1'b1;
        end
        else if (!blocked_q)
        begin
          err_set = 1'b1;
        end
      end
      else if (want != 4'h0)
      begin
        start = 1'b1;
      end
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q    <= S_IDLE;
      left_q     <= 4'h0;
      o_mem_req  <= 1'b0;
      o_mem_addr <= 32'h00000000;
      o_mem_data <= 32'h00000000;
      o_mem_last <= 1'b0;
      wp_q       <= `RDQ_RST_REG;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          if (host_wr)
          begin
            wp_q <= i_wdata;
          end
          if (start)
          begin
            state_q    <= S_XFER;
            left_q     <= burst_n;
            o_mem_req  <= 1'b1;
            o_mem_addr <= base + {14'h0000, wp_q, 2'b00};
            o_mem_data <= head;
            o_mem_last <= (burst_n == 4'h1);
          end
        end
        S_XFER:
        begin
          if (i_mem_ack)
          begin
            wp_q      <= wp_adv;
            o_mem_req <= 1'b0;
            left_q    <= left_q - 4'h1;
            state_q   <= (left_q == 4'h1) ? S_IDLE : S_NEXT;
          end
        end
        S_NEXT:
        begin
          // one idle cycle lets the next head settle so outputs stay registered
          state_q    <= S_XFER;
          o_mem_req  <= 1'b1;
          o_mem_addr <= base + {14'h0000, wp_q, 2'b00};
          o_mem_data <= head;
          o_mem_last <= (left_q == 4'h1);
        end
        default:
        begin
          state_q   <= S_IDLE;
          o_mem_req <= 1'b0;
        end
      endcase
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      blocked_q <= 1'b0;
    end
    else if (i_wr && (i_addr == `RDQ_OFF_RD_PTR))
    begin
      blocked_q <= 1'b0;
    end
    else if (err_set && burst_en)
    begin
      // a full queue flags once, then waits for the host to free room
      blocked_q <= 1'b1;
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pre_q <= 8'h00;
      tmr_q <= 17'h00000;
    end
    else
    begin
      pre_q <= pre_q + 8'h01;
      if (!burst_en || ack)
      begin
        tmr_q <= (reload_q == 16'hFFFF) ? `RDQ_TIMER_MAX : {1'b0, reload_q};
      end
      else if ((pre_q == 8'hFF) && (tmr_q != 17'h00000))
      begin
        tmr_q <= tmr_q - 17'h00001;
      end
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wcnt_q <= 8'h00;
    end
    else if (done_set)
    begin
      wcnt_q <= 8'h00;
    end
    else if (ack)
    begin
      wcnt_q <= wcnt_inc[7:0];
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      base_lo_q <= `RDQ_RST_REG;
      base_hi_q <= `RDQ_RST_REG;
      end_q     <= `RDQ_RST_REG;
      rp_q      <= `RDQ_RST_REG;
      reload_q  <= `RDQ_RST_REG;
      ctrl_q    <= `RDQ_RST_REG;
      ien_q     <= 2'b00;
    end
    else if (i_wr)
    begin
      case (i_addr)
        `RDQ_OFF_BASE_LO: base_lo_q <= i_wdata;
        `RDQ_OFF_BASE_HI: base_hi_q <= i_wdata;
        `RDQ_OFF_END:     end_q     <= i_wdata;
        `RDQ_OFF_RD_PTR:  rp_q      <= i_wdata;
        `RDQ_OFF_TIMER:   reload_q  <= i_wdata;
        `RDQ_OFF_CTRL:    ctrl_q    <= i_wdata & `RDQ_CTRL_MASK;
        `RDQ_OFF_IRQ_EN:  ien_q     <= i_wdata[1:0];
        default:          ien_q     <= ien_q;
      endcase
    end
  end

  // write-one-to-clear; a new event in the same cycle keeps the bit set
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stat_q <= 2'b00;
    end
    else
    begin
      stat_q[`RDQ_STAT_DONE] <= done_set ||
        (stat_q[`RDQ_STAT_DONE] && !(i_wr && (i_addr == `RDQ_OFF_STATUS) && i_wdata[`RDQ_STAT_DONE]));
      stat_q[`RDQ_STAT_ERR] <= err_set ||
        (stat_q[`RDQ_STAT_ERR] && !(i_wr && (i_addr == `RDQ_OFF_STATUS) && i_wdata[`RDQ_STAT_ERR]));
    end
  end

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_irq       <= 1'b0;
      o_buf_ready <= 1'b0;
      o_rdata     <= 16'h0000;
    end
    else
    begin
      o_irq       <= |(stat_q & ien_q);
      // ready is registered, so it leaves room for the push already in flight
      o_buf_ready <= i_rx_dma_enable && (cnt_nx < DEPTH[3:0] - 4'h1);
      if (i_rd)
      begin
        case (i_addr)
          `RDQ_OFF_BASE_LO: o_rdata <= base_lo_q;
          `RDQ_OFF_BASE_HI: o_rdata <= base_hi_q;
          `RDQ_OFF_END:     o_rdata <= end_q;
          `RDQ_OFF_RD_PTR:  o_rdata <= rp_q;
          `RDQ_OFF_WR_PTR:  o_rdata <= wp_q;
          `RDQ_OFF_TIMER:   o_rdata <= reload_q;
          `RDQ_OFF_CTRL:    o_rdata <= ctrl_q;
          `RDQ_OFF_STATUS:  o_rdata <= {14'h0000, stat_q};
          `RDQ_OFF_IRQ_EN:  o_rdata <= {14'h0000, ien_q};
          default:          o_rdata <= 16'h0000;
        endcase
      end
      else
      begin
        o_rdata <= 16'h0000;
      end
    end
  end
endmodule // rdq_writer

// ---- test/rdq_writer_chk.sv ----
// port checker for the done-queue writer
`timescale 1ns/100ps
`include "rdq_consts.vh"
module rdq_writer_chk (
  input wire               i_mclk,
  input wire               i_rst_n,
  input wire [`RDQ_AW-1:0] i_addr,
  input wire [`RDQ_DW-1:0] i_wdata,
  input wire               i_wr,
  input wire               i_rd,
  input wire [`RDQ_DW-1:0] o_rdata,
  input wire               i_rx_dma_enable,
  input wire               o_buf_ready,
  input wire               o_mem_req,
  input wire [31:0]        o_mem_addr,
  input wire [31:0]        o_mem_data,
  input wire               o_mem_last,
  input wire               i_mem_ack
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  // burst mode tracked from host writes, so single-mode checks need no design internals
  logic seen_q;
  logic burst_q;
  always @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      seen_q <= 1'b0;
      burst_q <= 1'b0;
    end
    else
    begin
      if (i_rx_dma_enable)
        seen_q <= 1'b1;
      if (i_wr && i_addr == `RDQ_OFF_CTRL)
        burst_q <= i_wdata[`RDQ_CTRL_BURST_EN];
    end
  sequence s_wait;
    o_mem_req && !i_mem_ack;
  endsequence
  sequence s_take;
    o_mem_req && i_mem_ack;
  endsequence
  sequence s_next;
    !o_mem_req ##1 o_mem_req;
  endsequence
  AST_REQ_HOLD: assert property (s_wait |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_data))
    else $error("request changed before ack");
  AST_REQ_DROP: assert property (s_take |=> !o_mem_req)
    else $error("request held after ack");
  AST_BURST_GAP: assert property ((s_take and !o_mem_last) |=> s_next)
    else $error("burst dword spacing wrong");
  AST_VALID_ZERO: assert property (o_mem_req |-> !o_mem_data[31])
    else $error("valid bit set in descriptor");
  AST_NO_POST: assert property (!seen_q |-> !o_mem_req)
    else $error("write before dma enable");
  AST_READY_OFF: assert property (!i_rx_dma_enable |=> !o_buf_ready)
    else $error("ready while dma disabled");
  AST_SINGLE: assert property (!burst_q && o_mem_req |-> o_mem_last)
    else $error("multi-dword write in single mode");
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read cycle");
endmodule // rdq_writer_chk
bind rdq_writer rdq_writer_chk i_rdq_writer_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_dma_enable(i_rx_dma_enable),
  .o_buf_ready(o_buf_ready), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data),
  .o_mem_last(o_mem_last), .i_mem_ack(i_mem_ack));

// ---- test/rdq_host_mem.sv ----
// host memory model taking done-queue dword writes
`timescale 1ns/100ps
module rdq_host_mem (
  input  wire        i_mclk,
  input  wire        i_req,
  input  wire [31:0] i_addr,
  input  wire [31:0] i_data,
  input  wire [3:0]  i_lat,
  output logic       o_ack
);
  logic [31:0] got_a[$];
  logic [31:0] got_d[$];
  int          got_t[$];
  int          cyc = 0;
  int          dly = 0;
  initial o_ack = 1'b0;
  // ack is a one-cycle pulse after i_lat idle cycles; a slow host stretches each dword
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    o_ack <= 1'b0;
    if (o_ack)
    begin
      got_a.push_back(i_addr);
      got_d.push_back(i_data);
      got_t.push_back(cyc);
      dly <= 0;
    end
    else if (i_req && dly >= int'(i_lat))
      o_ack <= 1'b1;
    else if (i_req)
      dly <= dly + 1;
  end
endmodule // rdq_host_mem

// ---- test/test_rdq_writer.sv ----
// self-checking bench for the done-queue writer
`timescale 1ns/100ps
`include "rdq_consts.vh"
module test_rdq_writer;
  localparam logic [31:0] BASE = 32'h80001000;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, en = 1'b0, bv = 1'b0, eof = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wd = 16'h0000, sq = 16'h0000, dp = 16'h0000;
  logic [2:0]  st = 3'h0, cnt = 3'h0, thr = 3'h0;
  logic [7:0]  ch = 8'h00;
  logic [3:0]  lat = 4'h0;
  wire  [15:0] rdata;
  wire  [31:0] maddr, mdata;
  wire         ready, req, mlast, ack, irq;
  logic [31:0] exq[$];
  int          miscompares = 0, checked = 0, wp = 0, last = 3, seen = 0, t0 = 0;
  initial forever #2 clk = ~clk;
  rdq_writer i_rdq_writer (.i_mclk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_rx_dma_enable(en), .i_buf_valid(bv), .i_buf_eof(eof), .i_buf_status(st),
    .i_buf_count(cnt), .i_buf_post_threshold(thr), .i_buf_channel(ch), .i_buf_desc_ptr(dp),
    .o_buf_ready(ready), .o_mem_req(req), .o_mem_addr(maddr), .o_mem_data(mdata), .o_mem_last(mlast),
    .i_mem_ack(ack), .o_irq(irq));
  rdq_host_mem i_rdq_host_mem (.i_mclk(clk), .i_req(req), .i_addr(maddr), .i_data(mdata), .i_lat(lat),
    .o_ack(ack));
  task automatic give_verdict;
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic hang;
    miscompares++;
    give_verdict();
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [11:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(n, e, rdata);
  endtask
  // the expected descriptor is queued only when the event should be posted
  task automatic post(input logic e, input logic [2:0] c, input logic [2:0] t);
    int k;
    k = 0;
    @(posedge clk);
    sq = sq + 16'h0001;
    eof <= e;
    cnt <= c;
    thr <= t;
    st <= sq[2:0];
    ch <= sq[7:0] ^ 8'hA5;
    dp <= sq;
    bv <= 1'b1;
    if (e || (t != 3'h0 && c >= t))
      exq.push_back({1'b0, e, sq[2:0], (t == 3'h0) ? 3'h0 : c, sq[7:0] ^ 8'hA5, sq});
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ready !== 1'b1 && k < 300);
    bv <= 1'b0;
    if (k >= 300)
      hang();
  endtask
  task automatic drain(input int n, input int lim);
    int k;
    k = 0;
    while (i_rdq_host_mem.got_a.size() < seen + n && k < lim)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= lim)
      hang();
    else
      repeat (n)
      begin
        chk("addr", BASE + 32'(4 * wp), i_rdq_host_mem.got_a[seen]);
        chk("desc", exq.pop_front(), i_rdq_host_mem.got_d[seen]);
        wp = (wp == last) ? 0 : wp + 1;
        seen++;
      end
  endtask
  task automatic quiet(input int c);
    repeat (c) @(posedge clk);
    chk("writes", seen, i_rdq_host_mem.got_a.size());
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rreg(`RDQ_OFF_TIMER, 16'h0000, "timer");
    rreg(12'h7F0, 16'h0000, "unmapped");
    wreg(`RDQ_OFF_CTRL, 16'hFFFF);
    rreg(`RDQ_OFF_CTRL, `RDQ_CTRL_MASK, "ctrl");
    wreg(`RDQ_OFF_CTRL, 16'h0100);
    wreg(`RDQ_OFF_BASE_LO, 16'h1000);
    wreg(`RDQ_OFF_BASE_HI, 16'h8000);
    wreg(`RDQ_OFF_END, 16'h0003);
    wreg(`RDQ_OFF_IRQ_EN, 16'h0003);
    chk("ready", 0, ready);
    @(posedge clk);
    en <= 1'b1;
    post(1'b1, 3'h1, 3'h0);
    drain(1, 200);
    rreg(`RDQ_OFF_STATUS, 16'h0000, "status");
    post(1'b0, 3'h1, 3'h2);
    post(1'b0, 3'h2, 3'h2);
    drain(1, 200);
    quiet(20);
    rreg(`RDQ_OFF_STATUS, 16'h0001, "status");
    chk("irq", 1, irq);
    wreg(`RDQ_OFF_STATUS, 16'h0003);
    rreg(`RDQ_OFF_STATUS, 16'h0000, "status");
    chk("irq", 0, irq);
    post(1'b1, 3'h3, 3'h4);
    drain(1, 200);
    post(1'b1, 3'h4, 3'h4);
    void'(exq.pop_back());
    quiet(30);
    rreg(`RDQ_OFF_WR_PTR, 16'h0003, "wptr");
    rreg(`RDQ_OFF_STATUS, 16'h0002, "status");
    chk("irq", 1, irq);
    wreg(`RDQ_OFF_STATUS, 16'h0003);
    wreg(`RDQ_OFF_RD_PTR, 16'h0002);
    post(1'b1, 3'h5, 3'h0);
    drain(1, 200);
    quiet(10);
    rreg(`RDQ_OFF_WR_PTR, 16'h0000, "wptr");
    rreg(`RDQ_OFF_STATUS, 16'h0001, "status");
    wreg(`RDQ_OFF_STATUS, 16'h0003);
    wreg(`RDQ_OFF_END, 16'h0007);
    wreg(`RDQ_OFF_RD_PTR, 16'h0000);
    wreg(`RDQ_OFF_TIMER, 16'h0010);
    wreg(`RDQ_OFF_CTRL, 16'h0010);
    last = 7;
    lat <= 4'h3;
    repeat (5) post(1'b1, 3'h1, 3'h0);
    quiet(40);
    post(1'b1, 3'h1, 3'h0);
    drain(6, 400);
    quiet(20);
    rreg(`RDQ_OFF_WR_PTR, 16'h0006, "wptr");
    rreg(`RDQ_OFF_STATUS, 16'h0001, "status");
    repeat (6) post(1'b1, 3'h2, 3'h0);
    drain(1, 400);
    quiet(40);
    wreg(`RDQ_OFF_CTRL, 16'h0030);
    quiet(40);
    rreg(`RDQ_OFF_STATUS, 16'h0003, "status");
    rreg(`RDQ_OFF_WR_PTR, 16'h0007, "wptr");
    wreg(`RDQ_OFF_RD_PTR, 16'h0004);
    drain(4, 400);
    quiet(40);
    t0 = i_rdq_host_mem.got_t[seen - 1];
    wreg(`RDQ_OFF_CTRL, 16'h0010);
    wreg(`RDQ_OFF_RD_PTR, 16'h0000);
    drain(1, 6000);
    chk("period", 1, (i_rdq_host_mem.got_t[seen - 1] - t0) inside {[3840:4120]});
    give_verdict();
  end
endmodule // test_rdq_writer
